/* File: hw/interval_timer.sv */
/*
  One-shot down counter: start loads a count, done pulses once at expiry.
  Assumes load is at least one; stop wins over start.
*/
`timescale 1ns/1ps
`default_nettype none

module interval_timer #(
  parameter int unsigned WIDTH = 32
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // control
  input  wire logic             start,
  input  wire logic             stop,
  input  wire logic [WIDTH-1:0] load,
  // status
  output logic                  busy,
  output logic                  done
);

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic             busy;
    logic             done;
  } timer_state_type;

  timer_state_type q;
  timer_state_type d;

  always_comb begin
    d      = q;
    d.done = 1'b0;
    if (stop) begin
      d.busy = 1'b0;
    end else if (start) begin
      d.cnt  = load - 1'b1;
      d.busy = 1'b1;
    end else if (q.busy) begin
      if (q.cnt == '0) begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end else begin
        d.cnt = q.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign busy = q.busy;
  assign done = q.done;

endmodule : interval_timer

`default_nettype wire

/* File: hw/sense_sync.sv */
/*
  Two-stage synchroniser for a bundle of asynchronous pins.
  Assumes each bit is an independent level; no bus coherence is given.
*/
`timescale 1ns/1ps
`default_nettype none

module sense_sync #(
  parameter int unsigned   WIDTH     = 18,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // pins in, synchronised out
  input  wire logic [WIDTH-1:0] pins,
  output logic      [WIDTH-1:0] synced
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_type;

  sync_state_type q;
  sync_state_type d;

  always_comb begin
    d        = q;
    d.stage1 = pins;
    d.stage2 = q.stage1;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q <= '{stage1: RESET_VAL, stage2: RESET_VAL};
    end else begin
      q <= d;
    end
  end

  assign synced = q.stage2;

endmodule : sense_sync

`default_nettype wire

/* File: hw/switch_monitor.sv */
/*
  Switch monitor control: SPI slave, operating modes, interrupt,
  polling with master/slave sync, wetting timer and APB status registers.
  Assumes analogue comparators and current sources outside; all pins
  are asynchronous to ref_clk and the serial clock is far below it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "switch_monitor_regs.svh"

module switch_monitor #(
  parameter int unsigned WET_CYCLES      = `SM_WET_TIME_MS * `SM_CLK_KHZ,
  parameter int unsigned POLL_ON_CYCLES  = `SM_POLL_ON_TIME_US * (`SM_CLK_KHZ / 1000),
  parameter int unsigned POLL_OFF_CYCLES = `SM_POLL_OFF_TIME_MS * `SM_CLK_KHZ,
  parameter int unsigned WAKE_CYCLES     = `SM_WAKE_TIME_MS * `SM_CLK_KHZ
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // spi pins
  input  wire logic        chip_select_n,
  input  wire logic        serial_clk,
  input  wire logic        serial_in,
  output logic             serial_out,
  output logic             serial_out_oe_n,
  // control pins
  input  wire logic        reset_n,
  input  wire logic        master_slave_select,
  input  wire logic        poll_sync_in,
  output logic             poll_sync_out,
  output logic             interrupt_n_out,
  output logic             interrupt_n_oe_n,
  // analogue front end
  input  wire logic [11:0] sense_compare,
  output logic      [11:0] sense_enable,
  output logic      [11:0] wetting_high,
  output logic      [3:0]  prog_to_battery,
  output logic      [11:0] metallic_select,
  output logic             osc_run
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  localparam int unsigned PINS = 18;
  localparam logic [PINS-1:0] PIN_RESET = 18'h00009;

  logic [PINS-1:0] pin_sync;

  sense_sync #(
    .WIDTH     (PINS),
    .RESET_VAL (PIN_RESET)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pins    ({sense_compare, poll_sync_in, master_slave_select,
               reset_n, serial_in, serial_clk, chip_select_n}),
    .synced  (pin_sync)
  );

  logic        cs_n_s;
  logic        sclk_s;
  logic        si_s;
  logic        rpin_n_s;
  logic        ms_s;
  logic        psync_s;
  logic [11:0] cmp_s;

  assign cs_n_s   = pin_sync[0];
  assign sclk_s   = pin_sync[1];
  assign si_s     = pin_sync[2];
  assign rpin_n_s = pin_sync[3];
  assign ms_s     = pin_sync[4];
  assign psync_s  = pin_sync[5];
  assign cmp_s    = pin_sync[17:6];

  ////////////////////////////////////////////////////////////////////////////
  // state

  localparam switch_monitor_pkg::core_state_type RESET_STATE = '{
    cs_d    : 1'b1,
    sync_en : `SM_CONTROL_RESET,
    mode    : switch_monitor_pkg::mode_sleep,
    default : '0
  };

  switch_monitor_pkg::core_state_type q;
  switch_monitor_pkg::core_state_type d;

  // two-bit mode code carried in the status word
  function automatic logic [1:0] mode_code(input switch_monitor_pkg::mode_type m);
    case (m)
      switch_monitor_pkg::mode_normal:     mode_code = `SM_RUN_NORMAL;
      switch_monitor_pkg::mode_poll:       mode_code = `SM_RUN_POLL;
      switch_monitor_pkg::mode_poll_timer: mode_code = `SM_RUN_POLL_TIMER;
      default:                             mode_code = 2'h0;
    endcase
  endfunction : mode_code

  function automatic logic is_poll(input switch_monitor_pkg::mode_type m);
    is_poll = (m == switch_monitor_pkg::mode_poll) ||
              (m == switch_monitor_pkg::mode_poll_timer);
  endfunction : is_poll

  ////////////////////////////////////////////////////////////////////////////
  // timers

  // timer 0 paces the polling phases, 1 is the wake-up interrupt, 2 the wetting pulse
  logic [2:0]  tmr_start;
  logic [2:0]  tmr_stop;
  logic [2:0]  tmr_busy;
  logic [2:0]  tmr_done;
  logic [31:0] tmr_load [3];

  for (genvar i = 0; i < 3; i++) begin : g_tmr
    interval_timer #(.WIDTH(32)) u_tmr (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .start   (tmr_start[i]),
      .stop    (tmr_stop[i]),
      .load    (tmr_load[i]),
      .busy    (tmr_busy[i]),
      .done    (tmr_done[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // sensing

  logic        is_master;
  logic        normal;
  logic        polling;
  logic        sensing;
  logic [11:0] decoded;
  logic [11:0] closed_live;
  logic [11:0] report;
  logic        int_act;
  logic        cs_fall;
  logic        cs_rise;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        slave_end;

  assign is_master = q.ms_strap;
  assign normal    = (q.mode == switch_monitor_pkg::mode_normal);
  assign polling   = is_poll(q.mode);
  assign sensing   = normal | q.poll_on;

  // ground inputs close low, battery inputs close high
  assign decoded = {~cmp_s[11:6], cmp_s[5:2] ~^ q.prog_bat, cmp_s[1:0]};
  assign closed_live = sensing ? decoded : 12'h000;
  // polling reports the last sample; sleep and tri-state read zero
  assign report = normal ? closed_live : (polling ? q.closed_q : 12'h000);

  // pin level is frozen at select fall for the whole frame
  assign int_act = q.cs_d ? (q.int_pend & (normal | q.poll_on)) : q.int_flag;

  assign cs_fall   = q.cs_d & ~cs_n_s;
  assign cs_rise   = ~q.cs_d & cs_n_s;
  assign sclk_rise = ~q.sclk_d & sclk_s & ~cs_n_s & ~q.cs_d;
  assign sclk_fall = q.sclk_d & ~sclk_s & ~cs_n_s & ~q.cs_d;
  assign slave_end = q.psync_d & ~psync_s;

  // master alternates off and on phases; a slave follows poll sync
  assign tmr_stop[0]  = ~polling | ~is_master | ~rpin_n_s;
  assign tmr_start[0] = ~tmr_busy[0];
  assign tmr_load[0]  = (q.poll_on ^ tmr_done[0]) ? POLL_ON_CYCLES : POLL_OFF_CYCLES;
  assign tmr_stop[1]  = (q.mode != switch_monitor_pkg::mode_poll_timer) | ~rpin_n_s;
  assign tmr_start[1] = ~tmr_busy[1];
  assign tmr_load[1]  = WAKE_CYCLES;
  assign tmr_stop[2]  = ~normal | ~rpin_n_s;
  assign tmr_start[2] = normal & |(closed_live & ~q.closed_q);
  assign tmr_load[2]  = WET_CYCLES;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic        int_event;
    logic [3:0]  op;
    logic [1:0]  run;
    int_event = 1'b0;
    op        = q.rx[`SM_CMD_OP_MSB:`SM_CMD_OP_LSB];
    run       = q.rx[`SM_RUN_MODE_MSB:`SM_RUN_MODE_LSB];
    d         = q;
    d.cs_d    = cs_n_s;
    d.sclk_d  = sclk_s;
    d.psync_d = psync_s;

    // strap follows the pin until the synchroniser holds a true sample
    if (q.strap_cnt != 2'h3) begin
      d.ms_strap  = ms_s;
      d.strap_cnt = q.strap_cnt + 2'h1;
    end

    // normal mode: any change interrupts, new closures wet high
    if (normal) begin
      if (closed_live != q.closed_q) begin
        int_event = 1'b1;
      end
      // a closure in the expiry cycle keeps its high current
      d.wet      = (tmr_done[2] ? 12'h000 : q.wet) | (closed_live & ~q.closed_q);
      d.closed_q = closed_live;
    end else begin
      d.wet = 12'h000;
    end

    // polling window and sample
    if (polling) begin
      d.poll_on = is_master ? (q.poll_on ^ tmr_done[0]) : psync_s;
      if ((is_master & tmr_done[0] & q.poll_on) | (~is_master & slave_end)) begin
        d.closed_q = decoded;
        if (|decoded) begin
          int_event = 1'b1;
          d.mode    = switch_monitor_pkg::mode_normal;
          d.poll_on = 1'b0;
        end
      end
      int_event = int_event | tmr_done[1];
    end else begin
      d.poll_on = 1'b0;
    end

    // serial shifting
    if (cs_fall) begin
      d.tx       = {int_act, q.ms_strap, mode_code(q.mode), report};
      d.int_flag = q.int_pend & (normal | q.poll_on);
      d.bit_cnt  = 5'h00;
      d.rx       = 16'h0000;
    end
    if (sclk_rise) begin
      d.rx = {q.rx[14:0], si_s};
      if (q.bit_cnt != 5'h1F) begin
        d.bit_cnt = q.bit_cnt + 5'h01;
      end
    end
    if (sclk_fall) begin
      d.tx = {q.tx[14:0], 1'b0};
    end

    // interrupt: an event never loses to the clear at select rise
    if (int_event) begin
      d.int_pend = 1'b1;
      if (!q.cs_d) begin
        d.int_late = 1'b1;
      end
    end
    if (cs_rise) begin
      d.int_pend = int_event | q.int_late;
      d.int_late = 1'b0;
      d.int_flag = 1'b0;
    end

    // command takes effect only on a full word at select rise
    if (cs_rise && q.bit_cnt == `SM_WORD_BITS) begin
      case (op)
        `SM_CMD_SLEEP: begin
          d.mode = switch_monitor_pkg::mode_sleep;
          d.cmd  = q.rx;
        end
        `SM_CMD_RUN: begin
          d.cmd      = q.rx;
          d.prog_bat = q.rx[3:0];
          case (run)
            `SM_RUN_NORMAL:     d.mode = switch_monitor_pkg::mode_normal;
            `SM_RUN_POLL:       d.mode = switch_monitor_pkg::mode_poll;
            `SM_RUN_POLL_TIMER: d.mode = switch_monitor_pkg::mode_poll_timer;
            default:            d.mode = q.mode;
          endcase
        end
        `SM_CMD_TRISTATE: begin
          d.mode = switch_monitor_pkg::mode_tristate;
          d.cmd  = q.rx;
        end
        `SM_CMD_METALLIC: begin
          d.metal = q.rx[11:0];
          d.cmd   = q.rx;
          if (q.mode == switch_monitor_pkg::mode_sleep) begin
            d.mode = switch_monitor_pkg::mode_normal;
          end
        end
        default: d.mode = q.mode;
      endcase
    end

    // reset pin: back to sleep with receive, interrupt, switch and command state cleared
    if (!rpin_n_s) begin
      d.mode     = switch_monitor_pkg::mode_sleep;
      d.poll_on  = 1'b0;
      d.rx       = 16'h0000;
      d.bit_cnt  = 5'h00;
      d.int_pend = 1'b0;
      d.int_late = 1'b0;
      d.int_flag = 1'b0;
      d.closed_q = 12'h000;
      d.wet      = 12'h000;
      d.prog_bat = 4'h0;
      d.metal    = 12'h000;
      d.cmd      = 16'h0000;
    end

    // apb: answer in the first access cycle
    d.ack    = psel & ~penable;
    d.slverr = 1'b0;
    if (psel && !penable) begin
      case (paddr)
        `SM_ADDR_STATUS:  d.rdata = {25'h0000000, q.poll_on, q.ms_strap, int_act,
                                     q.int_pend, q.mode};
        `SM_ADDR_SWITCH:  d.rdata = {20'h00000, report};
        `SM_ADDR_COMMAND: d.rdata = {16'h0000, q.cmd};
        `SM_ADDR_CONTROL: d.rdata = {31'h00000000, q.sync_en};
        default: begin
          d.rdata  = 32'h00000000;
          d.slverr = 1'b1;
        end
      endcase
    end
    if (psel && penable && q.ack && pwrite && paddr == `SM_ADDR_CONTROL) begin
      d.sync_en = pwdata[`SM_CTRL_SYNC_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q <= RESET_STATE;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata  = q.rdata;
  assign pready  = q.ack;
  assign pslverr = q.ack & q.slverr;

  assign serial_out      = q.tx[15];
  assign serial_out_oe_n = q.cs_d;

  // open drain: only ever pulls low
  assign interrupt_n_out  = 1'b0;
  assign interrupt_n_oe_n = ~int_act;

  assign poll_sync_out   = is_master & q.poll_on & q.sync_en;
  assign sense_enable    = sensing ? 12'hFFF : 12'h000;
  assign wetting_high    = q.wet;
  assign prog_to_battery = q.prog_bat;
  assign metallic_select = q.metal;
  // a slave stops its oscillator between sync windows
  assign osc_run = (q.mode != switch_monitor_pkg::mode_sleep) &
                   (~polling | is_master | q.poll_on | psync_s);

endmodule : switch_monitor

`default_nettype wire

/* File: shared/switch_monitor_pkg.sv */
/*
  Types of the switch monitor: operating modes and the core state record.
  Assumes nothing beyond a SystemVerilog tool.
*/
package switch_monitor_pkg;

  typedef enum logic [2:0] {
    mode_sleep,
    mode_normal,
    mode_poll,
    mode_poll_timer,
    mode_tristate
  } mode_type;

  typedef struct packed {
    mode_type     mode;
    logic         poll_on;
    logic         psync_d;
    logic         cs_d;
    logic         sclk_d;
    logic [15:0]  rx;
    logic [15:0]  tx;
    logic [4:0]   bit_cnt;
    logic         int_pend;
    logic         int_late;
    logic         int_flag;
    logic [11:0]  closed_q;
    logic [11:0]  wet;
    logic [3:0]   prog_bat;
    logic [11:0]  metal;
    logic [15:0]  cmd;
    logic         ms_strap;
    logic [1:0]   strap_cnt;
    logic         sync_en;
    logic         ack;
    logic         slverr;
    logic [31:0]  rdata;
  } core_state_type;

endpackage : switch_monitor_pkg

/* File: shared/switch_monitor_regs.svh */
/*
  Constants of the switch monitor: register offsets, field positions,
  reset values, command codes and timing figures.
  Assumes a 100 MHz ref_clk and byte addresses on an 8-bit APB paddr.
*/
//
// Contract
// - capture serial input on each rising serial clock while selected
// - shifted word becomes active command only at select release
// - serial output high impedance while deselected, driven once selected
// - open switch reads zero, closed switch reads one
// - select fall presents bit 15; each later clock fall the next bit
// - command and status both shift most significant bit first
// - polling master runs oscillator and wakes slave via poll sync
// - normal mode interrupts on any switch open/closed change
// - interrupt and flag latched at select fall; flag is inverse pin level
// - interrupt cleared on every select rise; code keeps it pending if an event came during the frame or at the rise
// - polling modes show interrupt only during sampling on-time
// - reset pin clears registers, timers, enters sleep, inputs high-Z
// - power-up clears all registers and starts in sleep; code resets the APB control sync bit to 1
// - sleep by command or reset pin; left only by run, tri-state, metallic
// - run command sets each programmable input to battery (1) or ground (0)
// - normal mode keeps sense currents on; status captured at select fall
// - normal mode enables high wetting current after crossing, off after 20 ms
// - polling continues while all open; closure interrupts and enters normal
// - timer polling: closure interrupts, goes normal; timer expiry interrupts, stays
// - tri-state disables inputs and comparators; status reads all zero; code still shows the master strap in bit 14
// - returned status reflects previously activated command or reset
// - top four command bits select command; other zero-top codes do nothing
// - run mode bits: 01 normal, 10 polling, 11 timer polling, 00 undefined
// - select rise activates word, then updates from switch inputs resume
`ifndef SWITCH_MONITOR_REGS_SVH
`define SWITCH_MONITOR_REGS_SVH

`define SM_ADDR_STATUS      8'h00
`define SM_ADDR_SWITCH      8'h04
`define SM_ADDR_COMMAND     8'h08
`define SM_ADDR_CONTROL     8'h0C
`define SM_CONTROL_RESET    1'h1
`define SM_CTRL_SYNC_BIT    0

`define SM_WORD_BITS        5'h10
`define SM_SW_INT_BIT       15
`define SM_SW_MS_BIT        14
`define SM_SW_MODE_MSB      13
`define SM_SW_MODE_LSB      12

`define SM_CMD_OP_MSB       15
`define SM_CMD_OP_LSB       12
`define SM_CMD_SLEEP        4'h0
`define SM_CMD_RUN          4'h1
`define SM_CMD_TRISTATE     4'h3
`define SM_CMD_METALLIC     4'h5
`define SM_RUN_MODE_MSB     11
`define SM_RUN_MODE_LSB     10
`define SM_RUN_NORMAL       2'h1
`define SM_RUN_POLL         2'h2
`define SM_RUN_POLL_TIMER   2'h3

`define SM_CLK_KHZ          100000
`define SM_WET_TIME_MS      20
`define SM_POLL_ON_TIME_US  5100
`define SM_POLL_OFF_TIME_MS 15
`define SM_WAKE_TIME_MS     2400

`endif

/* File: testbench/spi_master_model.sv */
/*
  Microcontroller model: SPI master, mode 0, MSB first.
  Assumes ref_clk; serial clock stands low outside frames.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_master_model #(
  parameter int HALF = 8
) (
  // clock
  input  wire logic ref_clk,
  // spi pins
  output logic      chip_select_n,
  output logic      serial_clk,
  output logic      serial_in
);
  initial begin
    chip_select_n = 1'b1;
    serial_clk    = 1'b0;
    serial_in     = 1'b0;
  end
  // nb below 16 makes a short frame that must be discarded
  task automatic xfer(input logic [15:0] cmd, input int nb);
    chip_select_n <= 1'b0;
    for (int i = 15; i > 15 - nb; i--) begin
      repeat (HALF) @(posedge ref_clk);
      serial_in <= cmd[i];
      repeat (HALF) @(posedge ref_clk);
      serial_clk <= 1'b1;
      repeat (HALF) @(posedge ref_clk);
      serial_clk <= 1'b0;
    end
    repeat (HALF) @(posedge ref_clk);
    chip_select_n <= 1'b1;
    serial_in     <= 1'b0;
    repeat (2 * HALF) @(posedge ref_clk);
  endtask : xfer
endmodule : spi_master_model
`default_nettype wire

/* File: testbench/switch_monitor_asserts.sv */
/*
  Port checker for the switch monitor.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module switch_monitor_asserts (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins
  input wire logic        chip_select_n,
  input wire logic        serial_out_oe_n,
  input wire logic        reset_n,
  input wire logic        interrupt_n_out,
  input wire logic        interrupt_n_oe_n,
  input wire logic [11:0] sense_enable
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////
  sequence s_idle;
    chip_select_n [*6];
  endsequence
  sequence s_setup;
    psel && !penable;
  endsequence
  // the pin synchroniser leaves up to five cycles of slack
  a_so_idle: assert property (s_idle |-> serial_out_oe_n)
    else $error("serial out driven while deselected");
  a_so_drive: assert property ($fell(chip_select_n) |-> ##[2:5] !serial_out_oe_n)
    else $error("serial out not driven after select");
  a_int_release: assert property ($rose(chip_select_n) |-> ##[2:5] interrupt_n_oe_n)
    else $error("interrupt not cleared at select rise");
  a_int_low: assert property (interrupt_n_out == 1'b0)
    else $error("interrupt data not low");
  a_int_sense: assert property (!interrupt_n_oe_n |-> sense_enable == 12'hFFF)
    else $error("interrupt shown outside sensing");
  a_pin_reset: assert property (!reset_n [*5] |-> sense_enable == 12'h000 && interrupt_n_oe_n)
    else $error("reset pin left inputs or interrupt on");
  a_apb_ready: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  a_apb_err: assert property (pslverr |-> pready && psel && penable)
    else $error("error outside access");
endmodule : switch_monitor_asserts
`default_nettype wire

/* File: testbench/switch_monitor_tb_top.sv */
/*
  Testbench top: apb master, spi partner, queue-checked monitors.
  Assumes shortened timer parameters and a polling master strap.
*/
`timescale 1ns/1ps
`default_nettype none
`include "switch_monitor_regs.svh"
module switch_monitor_tb_top;
  typedef struct packed {
    logic [32:0] val;
    logic [32:0] msk;
  } note_type;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, serial_out, serial_out_oe_n, so_hold = 1'b0;
  logic        chip_select_n, serial_clk, serial_in, poll_sync_out, osc_run;
  logic        reset_n = 1'b1, interrupt_n_out, interrupt_n_oe_n, ms_sel = 1'b1, psync_in = 1'b0;
  logic [11:0] sense_compare = 12'hFFC, sense_enable, wetting_high, metallic_select;
  logic [3:0]  prog_to_battery, prog;
  logic [15:0] sh, run;
  logic [15:0] nops [5] = '{16'h2000, 16'h4000, 16'h6000, 16'h7000, 16'h8000};
  note_type    apb_q[$], spi_q[$], na, ns;
  int          nb, n_fail = 0, compares = 0;
  wire         so_w = serial_out_oe_n ? ~so_hold : serial_out;
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (!serial_out_oe_n) so_hold <= serial_out;
  switch_monitor #(.WET_CYCLES(50), .POLL_ON_CYCLES(20), .POLL_OFF_CYCLES(30), .WAKE_CYCLES(200)) uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chip_select_n(chip_select_n), .serial_clk(serial_clk), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n), .reset_n(reset_n),
    .master_slave_select(ms_sel), .poll_sync_in(psync_in), .poll_sync_out(poll_sync_out),
    .interrupt_n_out(interrupt_n_out), .interrupt_n_oe_n(interrupt_n_oe_n),
    .sense_compare(sense_compare), .sense_enable(sense_enable), .wetting_high(wetting_high),
    .prog_to_battery(prog_to_battery), .metallic_select(metallic_select), .osc_run(osc_run));
  spi_master_model bus (.ref_clk(ref_clk), .chip_select_n(chip_select_n), .serial_clk(serial_clk),
    .serial_in(serial_in));
  ////////////////////////////////////////////////////////////////
  function automatic logic [11:0] open_sc(input logic [3:0] p);
    return {6'h3F, ~p, 2'b00};
  endfunction : open_sc
  function automatic logic [11:0] closed(input logic [11:0] s, input logic [3:0] p);
    return {~s[11:6], s[5:2] ~^ p, s[1:0]};
  endfunction : closed
  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1 && k < 50) begin
      k++;
      @(posedge ref_clk);
    end
    if (k == 50) n_fail++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
    apb_q.push_back('{e, m});
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic spi(input logic [15:0] c, input logic [15:0] e, input logic [15:0] m);
    spi_q.push_back('{{17'h0, e}, {17'h0, m}});
    bus.xfer(c, 16);
  endtask : spi
  task automatic wait_int(input int lim);
    int k;
    k = 0;
    while (interrupt_n_oe_n !== 1'b0 && k < lim) begin
      k++;
      @(posedge ref_clk);
    end
    chk("interrupt pin", interrupt_n_oe_n, 1'b0);
  endtask : wait_int
  ////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) if (psel && penable && pready === 1'b1 && !pwrite && apb_q.size() > 0) begin
    na = apb_q.pop_front();
    chk("apb read", {pslverr, prdata} & na.msk, na.val & na.msk);
  end
  always @(negedge chip_select_n) nb = 0;
  always @(posedge serial_clk) if (!chip_select_n) begin
    sh = {sh[14:0], so_w};
    nb++;
  end
  always @(posedge chip_select_n) if (nb == 16 && spi_q.size() > 0) begin
    ns = spi_q.pop_front();
    chk("spi status", {17'h0, sh} & ns.msk, ns.val & ns.msk);
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    report_and_stop();
  end
  initial begin
    void'($urandom(75528));
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk("sense idle", sense_enable, 33'h0);
    rd(`SM_ADDR_STATUS, 33'h0, 33'h7);
    rd(`SM_ADDR_CONTROL, 33'h1, '1);
    prog = $urandom;
    sense_compare <= open_sc(prog);
    run = {4'h1, 2'b01, 6'h00, prog};
    spi(16'h0000, 16'h4000, 16'hF000);
    spi(run, 16'h4000, 16'hF000);
    repeat (10) @(posedge ref_clk);
    chk("sense on", sense_enable, 33'hFFF);
    chk("prog", prog_to_battery, prog);
    rd(`SM_ADDR_COMMAND, {17'h0, run}, '1);
    bus.xfer(16'h0000, 15);
    foreach (nops[i])
      spi(nops[i], 16'h5000, 16'hFFFF);
    rd(`SM_ADDR_STATUS, 33'h1, 33'h7);
    $display("test normal setup done");
    sense_compare <= open_sc(prog) ^ (12'($urandom) | 12'h001);
    wait_int(20);
    repeat (2) @(posedge ref_clk);
    chk("wetting on", wetting_high != 12'h000, 33'h1);
    spi(run, {4'hD, closed(sense_compare, prog)}, 16'hFFFF);
    chk("interrupt cleared", interrupt_n_oe_n, 33'h1);
    chk("wetting off", wetting_high, 33'h0);
    spi(16'h3000, {4'h5, closed(sense_compare, prog)}, 16'hFFFF);
    spi(16'h3000, 16'h4000, 16'hFFFF);
    chk("tristate sense", sense_enable, 33'h0);
    $display("test normal and tristate done");
    sense_compare <= open_sc(prog);
    spi({4'h1, 2'b10, 6'h00, prog}, 16'h4000, 16'hF000);
    for (int k = 0; k < 100 && sense_enable !== 12'hFFF; k++) @(posedge ref_clk);
    @(posedge ref_clk);
    chk("osc", osc_run, 33'h1);
    chk("sync out", poll_sync_out, 33'h1);
    chk("no interrupt", interrupt_n_oe_n, 33'h1);
    sense_compare <= open_sc(prog) | 12'h001;
    wait_int(200);
    rd(`SM_ADDR_STATUS, 33'h1, 33'h7);
    sense_compare <= open_sc(prog);
    repeat (5) @(posedge ref_clk);
    spi({4'h1, 2'b11, 6'h00, prog}, 16'hD000, 16'hFFFF);
    wait_int(600);
    rd(`SM_ADDR_STATUS, 33'h3, 33'h7);
    $display("test polling done");
    reset_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk("reset sense", sense_enable, 33'h0);
    reset_n <= 1'b1;
    repeat (100) @(posedge ref_clk);
    rd(`SM_ADDR_STATUS, 33'h0, 33'h7);
    apb(1'b1, `SM_ADDR_CONTROL, 32'h0);
    rd(`SM_ADDR_CONTROL, 33'h0, '1);
    apb(1'b1, `SM_ADDR_STATUS, 32'hFFFFFFFF);
    rd(`SM_ADDR_STATUS, 33'h0, 33'h7);
    rd(8'h10, 33'h100000000, '1);
    run = {4'h5, 12'($urandom)};
    spi(run, 16'h4000, 16'hF000);
    chk("metallic", metallic_select, run[11:0]);
    rd(`SM_ADDR_STATUS, 33'h1, 33'h7);
    $display("test reset pin and apb done");
    repeat (5) @(posedge ref_clk);
    report_and_stop();
  end
endmodule : switch_monitor_tb_top
bind switch_monitor switch_monitor_asserts sva (
  .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .chip_select_n(chip_select_n), .serial_out_oe_n(serial_out_oe_n),
  .reset_n(reset_n), .interrupt_n_out(interrupt_n_out), .interrupt_n_oe_n(interrupt_n_oe_n),
  .sense_enable(sense_enable));
`default_nettype wire
